/* sfwr_defines.svh */
`ifndef SFWR_DEFINES_SVH
`define SFWR_DEFINES_SVH
// Register indices; byte address is four times the index
`define SFWR_A_IN_RD 16'h7800
`define SFWR_A_IN_CNT 16'h7801
`define SFWR_A_IN_LVI 16'h7802
`define SFWR_A_IN_LVP 16'h7803
`define SFWR_B_IN_RD 16'h7805
`define SFWR_B_IN_CNT 16'h7806
`define SFWR_B_IN_LVI 16'h7807
`define SFWR_B_IN_LVP 16'h7808
`define SFWR_IN_TF 16'h780a
`define SFWR_IN_IE 16'h780b
`define SFWR_IN_IRQ 16'h780c
`define SFWR_A_OUT_WR 16'h780e
`define SFWR_A_OUT_CNT 16'h780f
`define SFWR_A_OUT_LVI 16'h7810
`define SFWR_A_OUT_LVP 16'h7811
`define SFWR_B_OUT_WR 16'h7813
`define SFWR_B_OUT_CNT 16'h7814
`define SFWR_B_OUT_LVI 16'h7815
`define SFWR_B_OUT_LVP 16'h7816
`define SFWR_OUT_TF 16'h7818
`define SFWR_OUT_IE 16'h7819
`define SFWR_OUT_IRQ 16'h781a
`define SFWR_SETUP 16'h781c
`define SFWR_POLAR 16'h781d
`define SFWR_FLUSH 16'h781e
`define SFWR_WFSEL 16'h7824
`define SFWR_IDLE_CS 16'h7825
`define SFWR_IDLE_LVL 16'h7826
`define SFWR_CTL_CFG 16'h7827
`define SFWR_ENG_ADR 16'h782a
`define SFWR_A_IN_TC 16'h782c
`define SFWR_A_OUT_TC 16'h782d
`define SFWR_A_KICK 16'h782e
`define SFWR_B_IN_TC 16'h7830
`define SFWR_B_OUT_TC 16'h7831
`define SFWR_B_KICK 16'h7832
`define SFWR_SGL_HI 16'h7834
`define SFWR_SGL_LAUNCH 16'h7835
`define SFWR_SGL_QUIET 16'h7836
`define SFWR_READY 16'h7838
`define SFWR_ABORT 16'h7839
`define SFWR_GEN_IE 16'h783b
`define SFWR_GEN_IRQ 16'h783c
`define SFWR_IFCFG 16'h784a
`define SFWR_PACF2 16'h784b
// Field masks, reset values and counts
`define SFWR_SETUP_MASK 8'h35
`define SFWR_CTLCFG_MASK 8'hbf
`define SFWR_POLAR_RST 6'h00
`define SFWR_IF_SLAVE 2'h3
`define SFWR_DEPTH 7'h40
`define SFWR_ENG_LEN 4'h4
`endif

/* sfwr_pkg.sv */
package sfwr_pkg;
	typedef enum logic {SFWR_ENG_IDLE, SFWR_ENG_RUN} sfwr_eng_t;
	// Synchronised pin group; ctl is boe, aoe, rd, wr, fifo_a_select_in, fifo_b_select_in
	typedef struct packed {
		logic ext_clk;
		logic clk_sel;
		logic [5:0] ctl;
		logic [7:0] a_bus;
		logic [7:0] b_bus;
	} sfwr_pins_t;
	typedef struct packed {
		logic [7:0][7:0] lvl;
		logic [1:0] in_tog;
		logic [1:0] out_tog;
		logic [5:0] in_ie;
		logic [5:0] out_ie;
		logic [7:0] setup;
		logic [5:0] polar;
		logic [7:0] wfsel;
		logic idle_drv;
		logic [7:0] idle_lvl;
		logic [7:0] ctl_cfg;
		logic [5:0] eng_adr;
		logic [3:0][7:0] tcnt;
		logic [7:0] sgl_hi;
		logic [7:0] sgl_lo;
		logic [2:0] gen_ie;
		logic [2:0] ifcfg;
		logic [1:0] pacf2;
	} sfwr_cfg_t;
endpackage : sfwr_pkg

/* sfwr_top.sv */
`timescale 1ns/1ps
`include "sfwr_defines.svh"
module sfwr_top import sfwr_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic clock_source_select_pin,
	input wire logic external_fifo_clock,
	input wire logic fifo_a_output_enable_in,
	input wire logic fifo_b_output_enable_in,
	input wire logic slave_read_strobe,
	input wire logic slave_write_strobe,
	input wire logic fifo_a_select_in,
	input wire logic fifo_b_select_in,
	input wire logic [7:0] a_bus_in,
	output logic [7:0] a_bus_out,
	output logic a_bus_oe,
	input wire logic [7:0] b_bus_in,
	output logic [7:0] b_bus_out,
	output logic b_bus_oe,
	output logic [3:0] flag_pins,
	output logic [5:0] waveform_control_out,
	output logic [15:0] engine_data_out,
	output logic engine_data_oe,
	output logic [5:0] engine_addr_out,
	output logic irq
);
	// ************************************************************
	// Pin synchroniser
	// ************************************************************
	sfwr_pins_t pin_raw, sync1_reg, sync2_reg;
	logic ext_prev_reg;
	logic tick;
	logic [5:0] act;
	assign pin_raw = {external_fifo_clock, clock_source_select_pin,
		fifo_b_output_enable_in, fifo_a_output_enable_in, slave_read_strobe,
		slave_write_strobe, fifo_a_select_in, fifo_b_select_in, a_bus_in, b_bus_in};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= {2'b00, ~`SFWR_POLAR_RST, 16'h0000}; // Idle strobes: no false transfer
			sync2_reg <= {2'b00, ~`SFWR_POLAR_RST, 16'h0000};
			ext_prev_reg <= 1'b0;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			ext_prev_reg <= sync2_reg.ext_clk;
		end
	end
	// Internal base ticks every cycle; external base on its rising edge
	assign tick = sync2_reg.clk_sel ? (sync2_reg.ext_clk & ~ext_prev_reg) : 1'b1;
	sfwr_cfg_t cfg_reg, cfg_next;
	assign act = ~(sync2_reg.ctl ^ cfg_reg.polar);
	// ************************************************************
	// APB decode
	// ************************************************************
	logic pready_reg, pready_next, pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg, prdata_next;
	logic [15:0] idx;
	logic setup, wr, rd, aligned, hit;
	logic [7:0] rmux;
	assign idx = paddr[17:2];
	assign aligned = paddr[1:0] == 2'h0;
	assign setup = psel & ~penable;
	assign wr = psel & penable & pready_reg & pwrite & aligned;
	assign rd = psel & penable & pready_reg & ~pwrite & aligned;
	function automatic logic wr_at(input logic [15:0] ix);
		return wr && idx == ix;
	endfunction : wr_at
	function automatic logic rd_at(input logic [15:0] ix);
		return rd && idx == ix;
	endfunction : rd_at
	// ************************************************************
	// FIFO storage: 0 A-in, 1 B-in, 2 A-out, 3 B-out
	// ************************************************************
	logic [7:0] mem [4][64];
	logic [3:0][5:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [3:0][6:0] cnt_reg, cnt_next;
	logic [3:0][7:0] wdat;
	logic [3:0] push, pop, do_push, do_pop;
	logic [3:0][2:0] flg;
	logic [3:0] pin_flag;
	logic flush;
	assign flush = wr_at(`SFWR_FLUSH);
	// Far side drives both strobes; device only samples them
	assign push[0] = tick & act[2] & act[1];
	assign push[1] = tick & act[2] & act[0];
	assign push[2] = wr_at(`SFWR_A_OUT_WR);
	assign push[3] = wr_at(`SFWR_B_OUT_WR);
	assign pop[0] = rd_at(`SFWR_A_IN_RD);
	assign pop[1] = rd_at(`SFWR_B_IN_RD);
	assign pop[2] = tick & act[3] & act[1];
	assign pop[3] = tick & act[3] & act[0];
	assign wdat = {pwdata[7:0], pwdata[7:0], sync2_reg.b_bus, sync2_reg.a_bus};
	always_comb begin
		wp_next = wp_reg;
		rp_next = rp_reg;
		cnt_next = cnt_reg;
		for (int i = 0; i < 4; i++) begin
			// Full FIFO drops the push, empty FIFO ignores the pop
			do_push[i] = push[i] && cnt_reg[i] != `SFWR_DEPTH;
			do_pop[i] = pop[i] && cnt_reg[i] != 7'h00;
			if (do_push[i])
				wp_next[i] = wp_reg[i] + 6'h01;
			if (do_pop[i])
				rp_next[i] = rp_reg[i] + 6'h01;
			cnt_next[i] = cnt_reg[i] + {6'h00, do_push[i]} - {6'h00, do_pop[i]};
			if (flush) begin
				wp_next[i] = 6'h00;
				rp_next[i] = 6'h00;
				cnt_next[i] = 7'h00;
			end
			flg[i][2] = cfg_reg.lvl[2*i][7] ? cnt_reg[i] >= cfg_reg.lvl[2*i][6:0] :
				cnt_reg[i] <= cfg_reg.lvl[2*i][6:0];
			pin_flag[i] = cfg_reg.lvl[2*i+1][7] ? cnt_reg[i] >= cfg_reg.lvl[2*i+1][6:0] :
				cnt_reg[i] <= cfg_reg.lvl[2*i+1][6:0];
			flg[i][1] = cnt_reg[i] == 7'h00;
			flg[i][0] = cnt_reg[i] == `SFWR_DEPTH;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
		end
	end
	// Storage carries no reset; only pointers define contents
	always_ff @(posedge pclk) begin
		for (int i = 0; i < 4; i++) begin
			if (do_push[i] && !flush)
				mem[i][wp_reg[i]] <= wdat[i];
		end
	end
	// ************************************************************
	// Waveform engine
	// ************************************************************
	sfwr_eng_t st_reg, st_next;
	logic [3:0] ecnt_reg, ecnt_next;
	logic single_reg, single_next, done;
	logic start, launch, abort;
	assign launch = wr_at(`SFWR_SGL_LAUNCH);
	assign start = launch | wr_at(`SFWR_A_KICK) | wr_at(`SFWR_B_KICK);
	assign abort = wr_at(`SFWR_ABORT);
	always_comb begin
		st_next = st_reg;
		ecnt_next = ecnt_reg;
		single_next = single_reg;
		done = 1'b0;
		case (st_reg)
			SFWR_ENG_IDLE: begin
				if (start && !abort) begin
					st_next = SFWR_ENG_RUN;
					ecnt_next = 4'h0;
					single_next = launch;
				end
			end
			SFWR_ENG_RUN: begin
				if (abort) begin
					st_next = SFWR_ENG_IDLE;
				end else if (tick) begin
					if (ecnt_reg == `SFWR_ENG_LEN - 4'h1) begin
						st_next = SFWR_ENG_IDLE;
						done = 1'b1;
					end else begin
						ecnt_next = ecnt_reg + 4'h1;
					end
				end
			end
			default: st_next = SFWR_ENG_IDLE;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= SFWR_ENG_IDLE;
			ecnt_reg <= 4'h0;
			single_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			ecnt_reg <= ecnt_next;
			single_reg <= single_next;
		end
	end
	// ************************************************************
	// Registers, events and read mux
	// ************************************************************
	logic [5:0] in_irq_reg, in_irq_next, out_irq_reg, out_irq_next;
	logic [2:0] gen_irq_reg, gen_irq_next;
	logic [11:0] flags, flags_prev_reg, rise;
	logic idle;
	assign idle = st_reg == SFWR_ENG_IDLE;
	assign flags = {flg[0], flg[1], flg[2], flg[3]};
	assign rise = flags & ~flags_prev_reg;
	always_comb begin
		cfg_next = cfg_reg;
		// Set wins over clear-on-read in the same cycle
		in_irq_next = (in_irq_reg & ~(rd_at(`SFWR_IN_IRQ) ? prdata_reg[5:0] : 6'h00))
			| rise[11:6];
		out_irq_next = (out_irq_reg & ~(rd_at(`SFWR_OUT_IRQ) ? prdata_reg[5:0] : 6'h00))
			| rise[5:0];
		gen_irq_next = (gen_irq_reg & ~(rd_at(`SFWR_GEN_IRQ) ? prdata_reg[2:0] : 3'h0))
			| {1'b0, done & single_reg, done};
		if (wr) begin
			case (idx)
				`SFWR_A_IN_LVI: cfg_next.lvl[0] = pwdata[7:0];
				`SFWR_A_IN_LVP: cfg_next.lvl[1] = pwdata[7:0];
				`SFWR_B_IN_LVI: cfg_next.lvl[2] = pwdata[7:0];
				`SFWR_B_IN_LVP: cfg_next.lvl[3] = pwdata[7:0];
				`SFWR_A_OUT_LVI: cfg_next.lvl[4] = pwdata[7:0];
				`SFWR_A_OUT_LVP: cfg_next.lvl[5] = pwdata[7:0];
				`SFWR_B_OUT_LVI: cfg_next.lvl[6] = pwdata[7:0];
				`SFWR_B_OUT_LVP: cfg_next.lvl[7] = pwdata[7:0];
				`SFWR_IN_TF: cfg_next.in_tog = pwdata[7:6];
				`SFWR_OUT_TF: cfg_next.out_tog = pwdata[7:6];
				`SFWR_IN_IE: cfg_next.in_ie = pwdata[5:0];
				`SFWR_OUT_IE: cfg_next.out_ie = pwdata[5:0];
				`SFWR_SETUP: cfg_next.setup = pwdata[7:0] & `SFWR_SETUP_MASK;
				`SFWR_POLAR: cfg_next.polar = pwdata[5:0];
				`SFWR_WFSEL: cfg_next.wfsel = pwdata[7:0];
				`SFWR_IDLE_CS: cfg_next.idle_drv = pwdata[0];
				`SFWR_IDLE_LVL: cfg_next.idle_lvl = pwdata[7:0];
				`SFWR_CTL_CFG: cfg_next.ctl_cfg = pwdata[7:0] & `SFWR_CTLCFG_MASK;
				`SFWR_ENG_ADR: cfg_next.eng_adr = pwdata[5:0];
				`SFWR_A_IN_TC: cfg_next.tcnt[0] = pwdata[7:0];
				`SFWR_A_OUT_TC: cfg_next.tcnt[1] = pwdata[7:0];
				`SFWR_B_IN_TC: cfg_next.tcnt[2] = pwdata[7:0];
				`SFWR_B_OUT_TC: cfg_next.tcnt[3] = pwdata[7:0];
				`SFWR_SGL_HI: cfg_next.sgl_hi = pwdata[7:0];
				`SFWR_SGL_LAUNCH: cfg_next.sgl_lo = pwdata[7:0];
				`SFWR_SGL_QUIET: cfg_next.sgl_lo = pwdata[7:0];
				`SFWR_GEN_IE: cfg_next.gen_ie = pwdata[2:0];
				`SFWR_IFCFG: cfg_next.ifcfg = pwdata[2:0];
				`SFWR_PACF2: cfg_next.pacf2 = pwdata[5:4];
				default: cfg_next = cfg_reg;
			endcase
		end
	end
	always_comb begin
		hit = aligned;
		case (idx)
			`SFWR_A_IN_RD: rmux = mem[0][rp_reg[0]];
			`SFWR_A_IN_CNT: rmux = {1'b0, cnt_reg[0]};
			`SFWR_B_IN_RD: rmux = mem[1][rp_reg[1]];
			`SFWR_B_IN_CNT: rmux = {1'b0, cnt_reg[1]};
			`SFWR_A_OUT_CNT: rmux = {1'b0, cnt_reg[2]};
			`SFWR_B_OUT_CNT: rmux = {1'b0, cnt_reg[3]};
			`SFWR_A_IN_LVI: rmux = cfg_reg.lvl[0];
			`SFWR_A_IN_LVP: rmux = cfg_reg.lvl[1];
			`SFWR_B_IN_LVI: rmux = cfg_reg.lvl[2];
			`SFWR_B_IN_LVP: rmux = cfg_reg.lvl[3];
			`SFWR_A_OUT_LVI: rmux = cfg_reg.lvl[4];
			`SFWR_A_OUT_LVP: rmux = cfg_reg.lvl[5];
			`SFWR_B_OUT_LVI: rmux = cfg_reg.lvl[6];
			`SFWR_B_OUT_LVP: rmux = cfg_reg.lvl[7];
			`SFWR_IN_TF: rmux = {cfg_reg.in_tog, flags[11:6]};
			`SFWR_OUT_TF: rmux = {cfg_reg.out_tog, flags[5:0]};
			`SFWR_IN_IE: rmux = {2'h0, cfg_reg.in_ie};
			`SFWR_IN_IRQ: rmux = {2'h0, in_irq_reg};
			`SFWR_OUT_IE: rmux = {2'h0, cfg_reg.out_ie};
			`SFWR_OUT_IRQ: rmux = {2'h0, out_irq_reg};
			`SFWR_SETUP: rmux = cfg_reg.setup;
			`SFWR_POLAR: rmux = {2'h0, cfg_reg.polar};
			`SFWR_WFSEL: rmux = cfg_reg.wfsel;
			`SFWR_IDLE_CS: rmux = {idle, 6'h00, cfg_reg.idle_drv};
			`SFWR_IDLE_LVL: rmux = cfg_reg.idle_lvl;
			`SFWR_CTL_CFG: rmux = cfg_reg.ctl_cfg;
			`SFWR_ENG_ADR: rmux = {2'h0, cfg_reg.eng_adr};
			`SFWR_A_IN_TC: rmux = cfg_reg.tcnt[0];
			`SFWR_A_OUT_TC: rmux = cfg_reg.tcnt[1];
			`SFWR_B_IN_TC: rmux = cfg_reg.tcnt[2];
			`SFWR_B_OUT_TC: rmux = cfg_reg.tcnt[3];
			`SFWR_SGL_HI: rmux = cfg_reg.sgl_hi;
			`SFWR_SGL_LAUNCH: rmux = cfg_reg.sgl_lo;
			`SFWR_SGL_QUIET: rmux = cfg_reg.sgl_lo;
			`SFWR_READY: rmux = {2'h0, sync2_reg.ctl};
			`SFWR_GEN_IE: rmux = {5'h00, cfg_reg.gen_ie};
			`SFWR_GEN_IRQ: rmux = {5'h00, gen_irq_reg};
			`SFWR_IFCFG: rmux = {5'h00, cfg_reg.ifcfg};
			`SFWR_PACF2: rmux = {2'h0, cfg_reg.pacf2, 4'h0};
			`SFWR_A_OUT_WR, `SFWR_B_OUT_WR, `SFWR_FLUSH, `SFWR_A_KICK,
			`SFWR_B_KICK, `SFWR_ABORT: rmux = 8'h00;
			default: begin
				rmux = 8'h00;
				hit = 1'b0;
			end
		endcase
	end
	// ************************************************************
	// Registered outputs
	// ************************************************************
	logic slave_mode;
	assign slave_mode = cfg_reg.ifcfg[1:0] == `SFWR_IF_SLAVE;
	assign pready_next = setup;
	assign pslverr_next = setup & ~hit;
	assign prdata_next = setup ? {24'h000000, rmux} : prdata_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= '0;
			cfg_reg.polar <= `SFWR_POLAR_RST;
			in_irq_reg <= 6'h00;
			out_irq_reg <= 6'h00;
			gen_irq_reg <= 3'h0;
			flags_prev_reg <= 12'h000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			a_bus_out <= 8'h00;
			a_bus_oe <= 1'b0;
			b_bus_out <= 8'h00;
			b_bus_oe <= 1'b0;
			flag_pins <= 4'h0;
			waveform_control_out <= 6'h00;
			engine_data_out <= 16'h0000;
			engine_data_oe <= 1'b0;
			engine_addr_out <= 6'h00;
			irq <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			in_irq_reg <= in_irq_next;
			out_irq_reg <= out_irq_next;
			gen_irq_reg <= gen_irq_next;
			flags_prev_reg <= flags;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
			a_bus_out <= mem[2][rp_next[2]];
			a_bus_oe <= slave_mode & act[4];
			b_bus_out <= mem[3][rp_next[3]];
			b_bus_oe <= slave_mode & act[5];
			flag_pins <= slave_mode ? pin_flag : 4'h0;
			waveform_control_out <= (st_next == SFWR_ENG_IDLE) ? cfg_next.idle_lvl[5:0] :
				~cfg_next.idle_lvl[5:0];
			engine_data_out <= {cfg_next.ifcfg[2] ? cfg_next.sgl_hi : 8'h00,
				cfg_next.sgl_lo};
			engine_data_oe <= (st_next == SFWR_ENG_RUN) | cfg_next.idle_drv;
			engine_addr_out <= cfg_next.eng_adr;
			irq <= |{in_irq_next & cfg_next.in_ie, out_irq_next & cfg_next.out_ie,
				gen_irq_next & cfg_next.gen_ie};
		end
	end
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	// ************************************************************
	// Assertions
	// ************************************************************
	a_ext_no_edge: assert property (@(posedge pclk) disable iff (!presetn)
		sync2_reg.clk_sel && !(sync2_reg.ext_clk && !ext_prev_reg)
		|=> cnt_reg[0] <= $past(cnt_reg[0]))
		else $error("A-in FIFO grew without an external clock edge");
	a_flush_empty: assert property (@(posedge pclk) disable iff (!presetn)
		flush |=> cnt_reg == '0 ##1 flags[10] && flags[7])
		else $error("Flush left a FIFO non-empty");
	a_kick_starts: assert property (@(posedge pclk) disable iff (!presetn)
		idle && (wr_at(`SFWR_A_KICK) || wr_at(`SFWR_B_KICK)) && !abort
		|=> st_reg == SFWR_ENG_RUN)
		else $error("Kick did not start the engine");
	a_launch_load: assert property (@(posedge pclk) disable iff (!presetn)
		idle && launch |=> st_reg == SFWR_ENG_RUN && cfg_reg.sgl_lo == $past(pwdata[7:0]))
		else $error("Launch did not store and start");
	a_quiet_idle: assert property (@(posedge pclk) disable iff (!presetn)
		idle && wr_at(`SFWR_SGL_QUIET) && !start |=> idle [*2])
		else $error("Quiet write started the engine");
	a_abort_stop: assert property (@(posedge pclk) disable iff (!presetn)
		abort |=> idle ##1 $stable(gen_irq_reg[0]) || !gen_irq_reg[0])
		else $error("Abort left the engine running");
	a_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
		cnt_reg[0] <= `SFWR_DEPTH && cnt_reg[2] <= `SFWR_DEPTH)
		else $error("FIFO count beyond depth");
	a_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		in_irq_reg[4] && !rd_at(`SFWR_IN_IRQ) |=> in_irq_reg[4])
		else $error("Input request bit lost without a read");
	a_idle_level: assert property (@(posedge pclk) disable iff (!presetn)
		idle [*2] ##0 $stable(cfg_reg.idle_lvl) |-> waveform_control_out == cfg_reg.idle_lvl[5:0])
		else $error("Idle control outputs differ from idle levels");
endmodule : sfwr_top

/* sfwr_far_end.sv */
`timescale 1ns/1ps
// ****************************************
// Far-side logic: drives strobes, selects and data
// ****************************************
module sfwr_far_end (
	input wire logic pclk,
	input wire logic ext_mode,
	input wire logic [5:0] pol,
	input wire logic [7:0] a_out,
	input wire logic [7:0] b_out,
	output logic ext_clk,
	output logic [5:0] ctl,
	output logic [7:0] a_bus,
	output logic [7:0] b_bus
);
	logic [5:0] act = 6'h00;
	// Pin level equals the programmed active level only while active
	assign ctl = ~(act ^ pol);
	initial begin
		ext_clk = 1'b0;
		a_bus = 8'h00;
		b_bus = 8'h00;
	end
	// One byte per call; the link clock only moves inside a transfer
	task automatic xfer(input logic rd, input logic sel_b, input logic [7:0] d,
		output logic [7:0] q);
		q = sel_b ? b_out : a_out;
		@(posedge pclk);
		act <= {rd & sel_b, rd & ~sel_b, rd, ~rd, ~sel_b, sel_b};
		if (sel_b) b_bus <= d;
		else a_bus <= d;
		if (ext_mode) begin
			// One 80 ns high link pulse, edges on falling pclk edges, clear of rising ones
			#50 ext_clk = 1'b1;
			#80 ext_clk = 1'b0;
			@(posedge pclk);
		end
		@(posedge pclk);
		act <= 6'h00;
		// A released bus must not keep showing the last byte
		a_bus <= ~a_bus;
		b_bus <= ~b_bus;
		repeat (6) @(posedge pclk);
	endtask : xfer
endmodule : sfwr_far_end

/* tb.sv */
`timescale 1ns/1ps
`include "sfwr_defines.svh"
`define SFWR_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
	$display("mismatch t=%0t got %h exp %h", $time, got, exp); end end
module tb import sfwr_pkg::*; ;
	typedef struct packed {logic skip; logic err; logic [7:0] data;} sfwr_exp_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [17:0] paddr = 18'h00000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, sel_pin, ext_clk, a_oe, b_oe, e_oe, irq;
	logic [5:0] pol, ctl, wctl, eadr;
	logic [7:0] a_in, b_in, a_out, b_out, v, d, h, q;
	logic [3:0] flags;
	logic [15:0] edata, idx;
	logic [7:0] bq[$];
	sfwr_exp_t exp_q[$];
	sfwr_exp_t e;
	int err_count = 0;
	int cmp_count = 0;
	int len;
	int oe_n = 0;
	always #10 pclk = ~pclk;
	sfwr_top sfwr_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clock_source_select_pin(sel_pin), .external_fifo_clock(ext_clk),
		.fifo_a_output_enable_in(ctl[4]), .fifo_b_output_enable_in(ctl[5]),
		.slave_read_strobe(ctl[3]), .slave_write_strobe(ctl[2]), .fifo_a_select_in(ctl[1]),
		.fifo_b_select_in(ctl[0]), .a_bus_in(a_in), .a_bus_out(a_out), .a_bus_oe(a_oe),
		.b_bus_in(b_in), .b_bus_out(b_out), .b_bus_oe(b_oe), .flag_pins(flags),
		.waveform_control_out(wctl), .engine_data_out(edata), .engine_data_oe(e_oe),
		.engine_addr_out(eadr), .irq(irq));
	sfwr_far_end sfwr_far_end_i (.pclk(pclk), .ext_mode(sel_pin), .pol(pol), .a_out(a_out),
		.b_out(b_out), .ext_clk(ext_clk), .ctl(ctl), .a_bus(a_in), .b_bus(b_in));
	// ****************************************
	// Bus tasks and read-data monitor
	// ****************************************
	task automatic close_out;
		if (err_count == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : close_out
	task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] wd,
		input logic [9:0] x);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, wd};
		if (!w) exp_q.push_back(x);
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
	endtask : xfer
	task automatic idle;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : idle
	task automatic wr(input logic [15:0] i, input logic [7:0] wd);
		xfer(1'b1, i, wd, 10'h200);
		idle();
	endtask : wr
	task automatic rd(input logic [15:0] i, input logic [9:0] x);
		xfer(1'b0, i, 8'h00, x);
		idle();
	endtask : rd
	task automatic wait_ctl(input logic [5:0] x);
		for (int i = 0; i < 20 && wctl !== x; i++) @(posedge pclk);
	endtask : wait_ctl
	// Cycles the engine spends running after a write to the given register
	task automatic run(input logic [15:0] i, input logic [7:0] wd);
		wr(i, wd);
		len = 0;
		wait_ctl(~v[5:0]);
		while (len < 40 && wctl === ~v[5:0]) begin
			len++;
			@(posedge pclk);
		end
	endtask : run
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			e = exp_q.pop_front();
			if (!e.skip) `SFWR_CHK({pslverr, e.err ? 8'h00 : prdata[7:0]}, {e.err, e.data})
		end
	end
	// Output-enable cycles seen on either data bus
	always @(posedge pclk) oe_n <= oe_n + a_oe + b_oe;
	initial begin
		#200000;
		err_count++;
		close_out();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		sel_pin = 1'b0;
		pol = 6'h00;
		void'($urandom(71));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`SFWR_A_IN_CNT, 10'h000);
		rd(16'h7804, 10'h100);
		`SFWR_CHK(flags, 4'h0)
		wr(`SFWR_IFCFG, {6'h00, `SFWR_IF_SLAVE});
		rd(`SFWR_IFCFG, 10'h003);
		`SFWR_CHK(flags, 4'hf)
		wr(`SFWR_A_IN_LVI, 8'h85);
		wr(`SFWR_B_IN_LVI, 8'h85);
		rd(`SFWR_B_IN_LVI, 10'h085);
		wr(`SFWR_IN_TF, 8'hc0);
		wr(`SFWR_IN_IE, 8'h00);
		rd(`SFWR_IN_IRQ, 10'h200);
		// Internal base, external base, then all six inputs active high. The polarity
		// flip is made on the idle external base, so the brief pin mismatch never ticks.
		for (int m = 0; m < 3; m++) begin
			if (m == 2) begin
				wr(`SFWR_POLAR, 8'h3f);
				pol <= 6'h3f;
				repeat (4) @(posedge pclk);
			end
			sel_pin <= (m == 1);
			@(posedge pclk);
			for (int b = 0; b < 2; b++) begin
				for (int k = 0; k < 3; k++) begin
					d = 8'($urandom);
					bq.push_back(d);
					sfwr_far_end_i.xfer(1'b0, b[0], d, q);
				end
				rd(b ? `SFWR_B_IN_CNT : `SFWR_A_IN_CNT, 10'h003);
				for (int k = 0; k < 3; k++)
					rd(b ? `SFWR_B_IN_RD : `SFWR_A_IN_RD, {2'b00, bq.pop_front()});
			end
		end
		sel_pin <= 1'b0;
		`SFWR_CHK(irq, 1'b0)
		wr(`SFWR_IN_IE, 8'h10);
		repeat (3) @(posedge pclk);
		`SFWR_CHK(irq, 1'b1)
		rd(`SFWR_IN_IRQ, 10'h012);
		repeat (3) @(posedge pclk);
		`SFWR_CHK(irq, 1'b0)
		wr(`SFWR_IN_IE, 8'h00);
		sfwr_far_end_i.xfer(1'b0, 1'b0, 8'h5a, q);
		rd(`SFWR_IN_TF, 10'h0c2);
		`SFWR_CHK(flags, 4'he)
		wr(`SFWR_FLUSH, 8'($urandom));
		rd(`SFWR_A_IN_CNT, 10'h000);
		for (int b = 0; b < 2; b++) begin
			for (int k = 0; k < 3; k++) begin
				d = 8'($urandom);
				bq.push_back(d);
				wr(b ? `SFWR_B_OUT_WR : `SFWR_A_OUT_WR, d);
			end
			wr(b ? `SFWR_B_OUT_CNT : `SFWR_A_OUT_CNT, 8'h55);
			rd(b ? `SFWR_B_OUT_CNT : `SFWR_A_OUT_CNT, 10'h003);
			repeat (2) @(posedge pclk);
			len = oe_n;
			for (int k = 0; k < 3; k++) begin
				sfwr_far_end_i.xfer(1'b1, b[0], 8'h00, q);
				d = bq.pop_front();
				`SFWR_CHK(q, d)
			end
			`SFWR_CHK(oe_n - len, 3)
			rd(b ? `SFWR_B_OUT_CNT : `SFWR_A_OUT_CNT, 10'h000);
		end
		// Engine: idle levels, kicks, launch, quiet store, abort
		v = 8'($urandom);
		h = 8'($urandom);
		wr(`SFWR_IDLE_LVL, v);
		wait_ctl(v[5:0]);
		`SFWR_CHK(wctl, v[5:0])
		`SFWR_CHK(e_oe, 1'b0)
		wr(`SFWR_IDLE_CS, 8'h01);
		`SFWR_CHK(e_oe, 1'b1)
		rd(`SFWR_IDLE_CS, 10'h081);
		wr(`SFWR_GEN_IE, 8'h01);
		wr(`SFWR_SGL_HI, h);
		wr(`SFWR_IFCFG, 8'h07);
		for (int k = 0; k < 3; k++) begin
			idx = (k == 0) ? `SFWR_A_KICK : (k == 1) ? `SFWR_B_KICK : `SFWR_SGL_LAUNCH;
			d = 8'($urandom);
			run(idx, d);
			`SFWR_CHK(len, 4)
			repeat (2) @(posedge pclk);
			`SFWR_CHK(irq, 1'b1)
			rd(`SFWR_GEN_IRQ, (k == 2) ? 10'h003 : 10'h001);
		end
		`SFWR_CHK(edata, {h, d})
		d = ~d;
		run(`SFWR_SGL_QUIET, d);
		`SFWR_CHK(len, 0)
		`SFWR_CHK(edata[7:0], d)
		sel_pin <= 1'b1;
		wr(`SFWR_A_KICK, 8'h00);
		wait_ctl(~v[5:0]);
		repeat (10) @(posedge pclk);
		`SFWR_CHK(wctl, ~v[5:0])
		wr(`SFWR_ABORT, 8'($urandom));
		wait_ctl(v[5:0]);
		`SFWR_CHK(wctl, v[5:0])
		rd(`SFWR_GEN_IRQ, 10'h000);
		close_out();
	end
endmodule : tb
